// ===== scw_bank.sv
// Purpose: write-only control word bank of the synthesizer
// Assumes: link clock idle while the load strobe is high
// Notes: words are captured on the filtered strobe rise
`timescale 1ns/1ps
module scw_bank #(
    parameter int unsigned WORD_BITS = 32
) (
    input  wire logic        CLOCK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        LINK_CLK_IN,
    input  wire logic        SERIAL_DATA_IN,
    input  wire logic        LOAD_STROBE_IN,
    input  wire logic        REF_IN,
    input  wire logic        LOCK_DETECT_IN,
    output logic             PD_POLARITY_OUT,
    output logic             POWER_DOWN_OUT,
    output logic             VCO_POWER_DOWN_OUT,
    output logic             COUNTER_HOLD_OUT,
    output logic             LD_RESET_OUT,
    output logic             CP_TRISTATE_OUT,
    output logic             COUNTER_RESET_OUT,
    output logic             FEEDBACK_DIRECT_OUT,
    output logic      [2:0]  OUTPUT_DIVIDER_SELECT_OUT,
    output logic             DIV_LOAD_OUT,
    output logic             BLEED_NEG_EN_OUT,
    output logic      [7:0]  BLEED_CURRENT_LEVEL_OUT,
    output logic             PRIMARY_OUTPUT_EN_OUT,
    output logic      [1:0]  PRIMARY_POWER_OUT,
    output logic             AUXILIARY_OUTPUT_EN_OUT,
    output logic      [1:0]  AUX_POWER_OUT,
    output logic      [1:0]  LOCK_DETECT_COUNT_OUT,
    output logic             LOSS_OF_LOCK_MODE_OUT,
    output logic      [15:0] LD_WINDOW_PS_OUT,
    output logic             FIXED_WORDS_OK_OUT
);
    if (WORD_BITS != scw_pkg::WORD_W) begin : g_chk
        $error("scw_bank: only 32-bit words are served");
    end

    typedef struct packed {
        logic              strobe_q;
        logic              ref_q;
        logic              pol;
        logic              pd;
        logic              cpt;
        logic              crst;
        logic              dbuf;
        logic              gbl;
        logic              nbl;
        logic              fbs;
        logic [2:0]        div_stg;
        logic [2:0]        div_act;
        logic [7:0]        bleed;
        logic              mute;
        logic              aux_en;
        logic [1:0]        aux_pw;
        logic              pri_en;
        logic [1:0]        pri_pw;
        logic              lsync;
        logic [1:0]        ld_cnt;
        logic              loss_mode;
        logic [1:0]        ld_prec;
        logic              ld_fixed;
        logic [31:0]       w5;
        logic [31:0]       w8;
        scw_pkg::scw_load_t lsm;
        logic              pri_on;
        logic              aux_on;
        logic              bleed_on;
        logic              cp_hz;
        logic              div_load;
        logic              fixed_ok;
        logic [15:0]       win_ps;
    } scw_state_t;

    scw_state_t st_r;
    scw_state_t st_nxt;

    logic [31:0] lnk_word;
    logic [2:0]  pin_s;
    logic        strobe_s;
    logic        ref_s;
    logic        lock_s;
    logic        wr;
    logic        ref_rise;
    logic [2:0]  w_div;
    logic [7:0]  w_bleed;

    // true when the captured word addresses the given slot
    function automatic logic is_addr(input logic [31:0] w, input logic [3:0] a);
        return w[scw_pkg::ADDR_W-1:0] == a;
    endfunction : is_addr

    // lock window in ps; fixed mode wins over the precision field
    function automatic logic [15:0] win_of(input logic fixed, input logic [1:0] prec);
        logic [15:0] v;
        v = scw_pkg::WIN_5NS_PS;
        if (fixed) begin
            v = scw_pkg::WIN_2P9NS_PS;
        end else begin
            unique case (prec)
                2'h0: v = scw_pkg::WIN_5NS_PS;
                2'h1: v = scw_pkg::WIN_6NS_PS;
                2'h2: v = scw_pkg::WIN_8NS_PS;
                2'h3: v = scw_pkg::WIN_12NS_PS;
            endcase
        end
        return v;
    endfunction : win_of

    // link-side shifter; its word is still while the strobe is high
    scw_shift #(
        .WIDTH (scw_pkg::WORD_W)
    ) u_shift (
        .link_clk_in (LINK_CLK_IN),
        .rst_n_in    (RST_N_IN),
        .data_in     (SERIAL_DATA_IN),
        .word_out    (lnk_word)
    );

    // strobe, reference and lock arrive from outside this clock
    scw_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk_in   (CLOCK_IN),
        .rst_n_in (RST_N_IN),
        .d_in     ({LOCK_DETECT_IN, REF_IN, LOAD_STROBE_IN}),
        .q_out    (pin_s)
    );

    assign strobe_s = pin_s[0];
    assign ref_s    = pin_s[1];
    assign lock_s   = pin_s[2];
    assign wr       = strobe_s & ~st_r.strobe_q; // see [R24]
    assign ref_rise = ref_s & ~st_r.ref_q;
    assign w_div    = lnk_word[scw_pkg::W6_DIV_LSB +: 3];
    assign w_bleed  = lnk_word[scw_pkg::W6_BLEED_LSB +: 8];

    // word capture and divider transfer; power-down never blocks writes
    always_comb begin
        st_nxt          = st_r;
        st_nxt.strobe_q = strobe_s;
        st_nxt.ref_q    = ref_s;
        st_nxt.div_load = 1'b0;
        if (wr && is_addr(lnk_word, scw_pkg::ADDR_W4)) begin // see [R7]
            st_nxt.dbuf = lnk_word[scw_pkg::W4_DBUF];
            st_nxt.pol  = lnk_word[scw_pkg::W4_POL]; // see [R1]
            st_nxt.pd   = lnk_word[scw_pkg::W4_PD]; // see [R2]
            st_nxt.cpt  = lnk_word[scw_pkg::W4_CPT];
            st_nxt.crst = lnk_word[scw_pkg::W4_CRST];
        end
        if (wr && is_addr(lnk_word, scw_pkg::ADDR_W5)) begin
            st_nxt.w5 = lnk_word;
        end
        if (wr && is_addr(lnk_word, scw_pkg::ADDR_W8)) begin
            st_nxt.w8 = lnk_word;
        end
        // output word; accepted during power-down too
        if (wr && is_addr(lnk_word, scw_pkg::ADDR_W6)) begin // see [R4]
            st_nxt.gbl     = lnk_word[scw_pkg::W6_GBL];
            st_nxt.nbl     = lnk_word[scw_pkg::W6_NBL]; // see [R9]
            st_nxt.fbs     = lnk_word[scw_pkg::W6_FBS]; // see [R11]
            st_nxt.div_stg = w_div;
            if (!st_r.dbuf) begin
                st_nxt.div_act = w_div; // see [R12]
            end
            st_nxt.bleed   = w_bleed; // see [R13]
            st_nxt.mute    = lnk_word[scw_pkg::W6_MUTE];
            st_nxt.aux_en  = lnk_word[scw_pkg::W6_AUX_EN]; // see [R15]
            st_nxt.aux_pw  = lnk_word[scw_pkg::W6_AUX_PW +: 2];
            st_nxt.pri_en  = lnk_word[scw_pkg::W6_PRI_EN]; // see [R16]
            st_nxt.pri_pw  = lnk_word[scw_pkg::W6_PRI_PW +: 2];
        end
        if (wr && is_addr(lnk_word, scw_pkg::ADDR_W7)) begin
            st_nxt.lsync     = lnk_word[scw_pkg::W7_LSYNC];
            st_nxt.ld_cnt    = lnk_word[scw_pkg::W7_CNT_LSB +: 2]; // see [R18]
            st_nxt.loss_mode = lnk_word[scw_pkg::W7_LOSS]; // see [R19]
            st_nxt.ld_prec   = lnk_word[scw_pkg::W7_PREC_LSB +: 2]; // see [R20]
            st_nxt.ld_fixed  = lnk_word[scw_pkg::W7_FIXED];
        end
        // word 0 releases the staged divider and loads the dividers
        if (wr && is_addr(lnk_word, scw_pkg::ADDR_W0)) begin
            st_nxt.div_act = st_r.div_stg; // see [R12]
        end
        // optional wait for the reference rise before the load pulse
        unique case (st_r.lsm)
            scw_pkg::LOAD_IDLE: begin
                if (wr && is_addr(lnk_word, scw_pkg::ADDR_W0)) begin
                    if (st_r.lsync) begin
                        st_nxt.lsm = scw_pkg::LOAD_WAIT; // see [R17]
                    end else begin
                        st_nxt.div_load = 1'b1;
                    end
                end
            end
            scw_pkg::LOAD_WAIT: begin
                if (ref_rise) begin
                    st_nxt.div_load = 1'b1; // see [R17]
                    st_nxt.lsm      = scw_pkg::LOAD_IDLE;
                end
            end
        endcase
        // gated outputs; a lost lock pulls the outputs when mute is set and the bleed when gated bleed is set
        st_nxt.pri_on   = st_r.pri_en & ~st_r.pd & ~(st_r.mute & ~lock_s); // see [R14]
        st_nxt.aux_on   = st_r.aux_en & ~st_r.pd & ~(st_r.mute & ~lock_s); // see [R3]
        st_nxt.bleed_on = st_r.nbl & ~st_r.pd & ~(st_r.gbl & ~lock_s); // see [R8]
        st_nxt.cp_hz    = st_r.cpt | st_r.pd; // see [R5]
        st_nxt.win_ps   = win_of(st_r.ld_fixed, st_r.ld_prec); // see [R21]
        st_nxt.fixed_ok = (st_r.w5 == scw_pkg::W5_VALUE) & (st_r.w8 == scw_pkg::W8_VALUE);
    end

    // only constants under reset; lsm resets to its idle code
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_r     <= '0;
            st_r.w5  <= scw_pkg::WORD_RESET;
            st_r.w8  <= scw_pkg::WORD_RESET;
            st_r.lsm <= scw_pkg::LOAD_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from state flip-flops
    assign PD_POLARITY_OUT           = st_r.pol;
    assign POWER_DOWN_OUT            = st_r.pd;
    assign VCO_POWER_DOWN_OUT        = st_r.pd; // see [R3]
    assign COUNTER_HOLD_OUT          = st_r.pd;
    assign LD_RESET_OUT              = st_r.pd;
    assign CP_TRISTATE_OUT           = st_r.cp_hz;
    assign COUNTER_RESET_OUT         = st_r.crst; // see [R6]
    assign FEEDBACK_DIRECT_OUT       = st_r.fbs;
    assign OUTPUT_DIVIDER_SELECT_OUT = st_r.div_act;
    assign DIV_LOAD_OUT              = st_r.div_load;
    assign BLEED_NEG_EN_OUT          = st_r.bleed_on;
    assign BLEED_CURRENT_LEVEL_OUT   = st_r.bleed;
    assign PRIMARY_OUTPUT_EN_OUT     = st_r.pri_on;
    assign PRIMARY_POWER_OUT         = st_r.pri_pw;
    assign AUXILIARY_OUTPUT_EN_OUT   = st_r.aux_on;
    assign AUX_POWER_OUT             = st_r.aux_pw;
    assign LOCK_DETECT_COUNT_OUT     = st_r.ld_cnt;
    assign LOSS_OF_LOCK_MODE_OUT     = st_r.loss_mode;
    assign LD_WINDOW_PS_OUT          = st_r.win_ps;
    assign FIXED_WORDS_OK_OUT        = st_r.fixed_ok;

    // checks on the system clock
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    property p_strobe_write;
        !LOAD_STROBE_IN [*4] ##1 LOAD_STROBE_IN [*4] |=> wr;
    endproperty
    a_strobe_write: assert property (p_strobe_write) // see [R24]
        else $error("strobe rise not taken as a write");

    property p_pd_stops;
        st_r.pd |=> !PRIMARY_OUTPUT_EN_OUT && !AUXILIARY_OUTPUT_EN_OUT && CP_TRISTATE_OUT;
    endproperty
    a_pd_stops: assert property (p_pd_stops) // see [R3]
        else $error("power-down left an output or the pump active");

    property p_pd_write;
        wr && is_addr(lnk_word, scw_pkg::ADDR_W6) && st_r.pd |=> st_r.bleed == $past(w_bleed);
    endproperty
    a_pd_write: assert property (p_pd_write) // see [R4]
        else $error("word lost during power-down");

    property p_pump_hz;
        st_r.cpt |=> CP_TRISTATE_OUT;
    endproperty
    a_pump_hz: assert property (p_pump_hz) // see [R5]
        else $error("pump not three-stated");

    property p_mute;
        st_r.mute && !lock_s |=> !PRIMARY_OUTPUT_EN_OUT && !AUXILIARY_OUTPUT_EN_OUT;
    endproperty
    a_mute: assert property (p_mute) // see [R14]
        else $error("output on before lock");

    property p_gated_bleed;
        st_r.gbl && !lock_s |=> !BLEED_NEG_EN_OUT;
    endproperty
    a_gated_bleed: assert property (p_gated_bleed) // see [R8]
        else $error("bleed on before lock");

    property p_div_held;
        wr && is_addr(lnk_word, scw_pkg::ADDR_W6) && st_r.dbuf |=> $stable(st_r.div_act);
    endproperty
    a_div_held: assert property (p_div_held) // see [R12]
        else $error("buffered divider changed early");

    property p_div_now;
        wr && is_addr(lnk_word, scw_pkg::ADDR_W6) && !st_r.dbuf
            |=> OUTPUT_DIVIDER_SELECT_OUT == $past(w_div);
    endproperty
    a_div_now: assert property (p_div_now) // see [R12]
        else $error("unbuffered divider not applied");

    property p_load_wait;
        st_r.lsm == scw_pkg::LOAD_WAIT && !ref_rise |=> !DIV_LOAD_OUT;
    endproperty
    a_load_wait: assert property (p_load_wait) // see [R17]
        else $error("divider load before reference rise");

    property p_load_now;
        wr && is_addr(lnk_word, scw_pkg::ADDR_W0) && !st_r.lsync
            && st_r.lsm == scw_pkg::LOAD_IDLE |=> DIV_LOAD_OUT ##1 !DIV_LOAD_OUT;
    endproperty
    a_load_now: assert property (p_load_now) // see [R17]
        else $error("unsynced divider load not a single pulse");

    property p_fixed_win;
        st_r.ld_fixed |=> LD_WINDOW_PS_OUT == scw_pkg::WIN_2P9NS_PS;
    endproperty
    a_fixed_win: assert property (p_fixed_win) // see [R21]
        else $error("fixed lock window not applied");

    property p_pol_write;
        wr && is_addr(lnk_word, scw_pkg::ADDR_W4)
            |=> PD_POLARITY_OUT == $past(lnk_word[scw_pkg::W4_POL]);
    endproperty
    a_pol_write: assert property (p_pol_write) // see [R1]
        else $error("polarity bit not taken");

    property p_pd_bit;
        wr && is_addr(lnk_word, scw_pkg::ADDR_W4)
            |=> POWER_DOWN_OUT == $past(lnk_word[scw_pkg::W4_PD]);
    endproperty
    a_pd_bit: assert property (p_pd_bit) // see [R2]
        else $error("power-down bit not taken");

    property p_crst_write;
        wr && is_addr(lnk_word, scw_pkg::ADDR_W4)
            |=> COUNTER_RESET_OUT == $past(lnk_word[scw_pkg::W4_CRST]);
    endproperty
    a_crst_write: assert property (p_crst_write) // see [R6]
        else $error("counter reset bit not taken");

    property p_fbs_write;
        wr && is_addr(lnk_word, scw_pkg::ADDR_W6)
            |=> FEEDBACK_DIRECT_OUT == $past(lnk_word[scw_pkg::W6_FBS]);
    endproperty
    a_fbs_write: assert property (p_fbs_write) // see [R11]
        else $error("feedback select not taken");

    // a word for another slot must leave the bleed level alone
    property p_bleed_kept;
        wr && !is_addr(lnk_word, scw_pkg::ADDR_W6) |=> $stable(BLEED_CURRENT_LEVEL_OUT);
    endproperty
    a_bleed_kept: assert property (p_bleed_kept) // see [R7]
        else $error("bleed level changed by another word");

    c_pd_write: cover property (wr && st_r.pd);
    c_sync_load: cover property (st_r.lsm == scw_pkg::LOAD_WAIT ##[1:200] DIV_LOAD_OUT);
    c_buffered: cover property (st_r.dbuf && wr && is_addr(lnk_word, scw_pkg::ADDR_W0));
    c_mute_release: cover property (st_r.mute && !lock_s ##[1:50] PRIMARY_OUTPUT_EN_OUT);
endmodule : scw_bank

// ===== scw_host.sv
// Purpose: host model that loads words over the serial link
// Assumes: system clock paces the load strobe
// Notes: link clock runs only inside frames, 12 ns period
`timescale 1ns/1ps
module scw_host (
    input  wire logic clk_in,
    output logic      link_clk_out,
    output logic      data_out,
    output logic      strobe_out
);
    initial begin
        link_clk_out = 1'b0;
        data_out = 1'b0;
        strobe_out = 1'b0;
    end
    // msb first, data moves on the falling link edge
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            data_out = w[i];
            #6 link_clk_out = 1'b1;
            #6 link_clk_out = 1'b0;
        end
        data_out = ~w[0]; // no pull on the line, so never leave the last bit
        repeat (2) @(posedge clk_in);
        strobe_out <= 1'b1;
        repeat (6) @(posedge clk_in);
        strobe_out <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask : send
endmodule : scw_host

// ===== scw_pkg.sv
// Purpose: constants for the synthesizer control word bank
// Assumes: 32-bit serial words, 4-bit word address in the low bits
// Notes: positions are bit indexes inside a serial word
// What the document asks of this block and its host
// [R1] polarity bit: 1 positive, 0 negative
// [R2] power-down bit powers down, contents kept
// [R3] power-down holds counters, lock, pump, outputs
// [R4] serial words still load while powered down
// [R5] pump three-state bit floats charge pump output
// [R6] counter reset bit holds counters; host toggles
// [R7] low 4 bits address the destination word
// [R8] gated bleed waits for digital lock
// [R9] negative bleed bit; host avoids above 100 MHz
// [R10] host writes 1010 below negative bleed bit
// [R11] feedback select: 1 oscillator, 0 divider output
// [R12] divider select buffered to word 0 if enabled
// [R13] 8-bit field sets bleed current level
// [R14] mute-until-lock keeps outputs off until lock
// [R15] auxiliary output enable and 2-bit power
// [R16] primary output enable and 2-bit power
// [R17] load-sync aligns divider load to reference rise
// [R18] 2-bit count of in-window cycles before lock
// [R19] loss-of-lock mode; host avoids differential reference
// [R20] precision selects 5, 6, 8, 12 ns window
// [R21] window mode 1 forces fixed 2.9 ns
// [R22] host writes word 5 as fixed value
// [R23] host writes word 8 as fixed value
// [R24] msb first on serial clock, latched at strobe
// [R25] host uses divided feedback with phase resync; the bench's random word 6 leaves feedback select bit 24 random
package scw_pkg;
    localparam int unsigned WORD_W       = 32;
    localparam int unsigned ADDR_W       = 4;
    localparam logic [3:0]  ADDR_W0      = 4'h0;
    localparam logic [3:0]  ADDR_W4      = 4'h4;
    localparam logic [3:0]  ADDR_W5      = 4'h5;
    localparam logic [3:0]  ADDR_W6      = 4'h6;
    localparam logic [3:0]  ADDR_W7      = 4'h7;
    localparam logic [3:0]  ADDR_W8      = 4'h8;
    // word 4 low control bits
    localparam int unsigned W4_DBUF      = 14;
    localparam int unsigned W4_POL       = 7;
    localparam int unsigned W4_PD        = 6;
    localparam int unsigned W4_CPT       = 5;
    localparam int unsigned W4_CRST      = 4;
    // output and bleed word
    localparam int unsigned W6_GBL       = 30;
    localparam int unsigned W6_NBL       = 29;
    localparam int unsigned W6_FBS       = 24;
    localparam int unsigned W6_DIV_LSB   = 21;
    localparam int unsigned W6_BLEED_LSB = 13;
    localparam int unsigned W6_MUTE      = 11;
    localparam int unsigned W6_AUX_EN    = 9;
    localparam int unsigned W6_AUX_PW    = 7;
    localparam int unsigned W6_PRI_EN    = 6;
    localparam int unsigned W6_PRI_PW    = 4;
    // lock detect word
    localparam int unsigned W7_LSYNC     = 25;
    localparam int unsigned W7_CNT_LSB   = 8;
    localparam int unsigned W7_LOSS      = 7;
    localparam int unsigned W7_PREC_LSB  = 5;
    localparam int unsigned W7_FIXED     = 4;
    // fixed reserved words and reset value of stored words
    localparam logic [31:0] W5_VALUE     = 32'h00800025;
    localparam logic [31:0] W8_VALUE     = 32'h102d0428;
    localparam logic [31:0] WORD_RESET   = 32'h00000000;
    // lock window widths in picoseconds: 5, 6, 8, 12 and 2.9 ns
    localparam logic [15:0] WIN_5NS_PS   = 16'h1388;
    localparam logic [15:0] WIN_6NS_PS   = 16'h1770;
    localparam logic [15:0] WIN_8NS_PS   = 16'h1f40;
    localparam logic [15:0] WIN_12NS_PS  = 16'h2ee0;
    localparam logic [15:0] WIN_2P9NS_PS = 16'h0b54;
    typedef enum logic {LOAD_IDLE, LOAD_WAIT} scw_load_t;
endpackage : scw_pkg

// ===== scw_shift.sv
// Purpose: serial word shifter on the link clock
// Assumes: host stops the link clock while the strobe is high
// Notes: word stays still between frames, read by the bank at strobe
`timescale 1ns/1ps
module scw_shift #(
    parameter int unsigned WIDTH = 32
) (
    input  wire logic             link_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             data_in,
    output logic      [WIDTH-1:0] word_out
);
    if (WIDTH < 8) begin : g_chk
        $error("scw_shift: WIDTH too small");
    end

    typedef struct packed {
        logic [WIDTH-1:0] word;
    } scw_shift_st_t;

    scw_shift_st_t st_r;
    scw_shift_st_t st_nxt;

    // msb enters first, so after the last edge it sits on top
    always_comb begin
        st_nxt      = st_r;
        st_nxt.word = {st_r.word[WIDTH-2:0], data_in}; // see [R24]
    end

    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign word_out = st_r.word;
endmodule : scw_shift

// ===== scw_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs change slower than a few system clocks
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
module scw_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    if (WIDTH < 1) begin : g_chk
        $error("scw_sync: WIDTH must be at least one");
    end

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } scw_sync_st_t;

    scw_sync_st_t st_r;
    scw_sync_st_t st_nxt;

    // s1 feeds only s2; the filter looks at s2 and s3
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.q  = ((st_r.s2 ~^ st_r.s3) & st_r.s2) | ((st_r.s2 ^ st_r.s3) & st_r.q);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_out = st_r.q;
endmodule : scw_sync

// ===== test_scw_bank.sv
// Purpose: self-checking bench for the control word bank
// Assumes: host model drives the link, bench drives reference and lock
// Notes: expectations come from shadow copies of the written words
`timescale 1ns/1ps
module test_scw_bank;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ref_r = 1'b0;
    logic        lock_r = 1'b0;
    logic        lclk, sdat, stb;
    logic        pol, pd, vpd, hold, ldr, cpt, crst, fbd, ld, nbl, pen, aen, loss_of_lock_mode, fok;
    logic [2:0]  div;
    logic [7:0]  blv;
    logic [1:0]  ppw, apw, lock_detect_count;
    logic [15:0] win;
    logic [31:0] w4 = '0, w5 = '0, w6 = '0, w7 = '0, w8 = '0;
    logic [2:0]  div_act = '0;
    logic [15:0] loads = '0, loads_exp = '0;
    int          bad_count = 0, checks = 0, cycles = 0;

    always #12.5 clk = ~clk;

    scw_host scw_host_i (.clk_in(clk), .link_clk_out(lclk), .data_out(sdat), .strobe_out(stb));
    scw_bank scw_bank_i (
        .CLOCK_IN(clk), .RST_N_IN(rst_n), .LINK_CLK_IN(lclk), .SERIAL_DATA_IN(sdat),
        .LOAD_STROBE_IN(stb), .REF_IN(ref_r), .LOCK_DETECT_IN(lock_r),
        .PD_POLARITY_OUT(pol), .POWER_DOWN_OUT(pd), .VCO_POWER_DOWN_OUT(vpd),
        .COUNTER_HOLD_OUT(hold), .LD_RESET_OUT(ldr), .CP_TRISTATE_OUT(cpt),
        .COUNTER_RESET_OUT(crst), .FEEDBACK_DIRECT_OUT(fbd),
        .OUTPUT_DIVIDER_SELECT_OUT(div), .DIV_LOAD_OUT(ld), .BLEED_NEG_EN_OUT(nbl),
        .BLEED_CURRENT_LEVEL_OUT(blv), .PRIMARY_OUTPUT_EN_OUT(pen), .PRIMARY_POWER_OUT(ppw),
        .AUXILIARY_OUTPUT_EN_OUT(aen), .AUX_POWER_OUT(apw), .LOCK_DETECT_COUNT_OUT(lock_detect_count),
        .LOSS_OF_LOCK_MODE_OUT(loss_of_lock_mode), .LD_WINDOW_PS_OUT(win), .FIXED_WORDS_OK_OUT(fok)
    );

    // count divider loads and cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (ld === 1'b1) loads++;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    function automatic logic [15:0] win_exp(input logic [31:0] w);
        if (w[4]) return 16'h0b54;
        case (w[6:5])
            2'h0: return 16'h1388;
            2'h1: return 16'h1770;
            2'h2: return 16'h1f40;
            default: return 16'h2ee0;
        endcase
    endfunction : win_exp

    // all outputs against the shadow words, away from the clock edge
    task automatic check_all();
        @(negedge clk);
        chk("pol", w4[7], pol);
        chk("pd", w4[6], pd);
        chk("vco", w4[6], vpd);
        chk("hold", w4[6], hold);
        chk("ldrst", w4[6], ldr);
        chk("cpt", w4[5] | w4[6], cpt);
        chk("crst", w4[4], crst);
        chk("fbs", w6[24], fbd);
        chk("div", div_act, div);
        chk("nbl", w6[29] & !w4[6] & !(w6[30] & !lock_r), nbl);
        chk("bleed", w6[20:13], blv);
        chk("pri", w6[6] & !w4[6] & !(w6[11] & !lock_r), pen);
        chk("ppw", w6[5:4], ppw);
        chk("aux", w6[9] & !w4[6] & !(w6[11] & !lock_r), aen);
        chk("apw", w6[8:7], apw);
        chk("ldc", w7[9:8], lock_detect_count);
        chk("lol", w7[7], loss_of_lock_mode);
        chk("win", win_exp(w7), win);
        chk("fixed", (w5 == 32'h00800025) && (w8 == 32'h102d0428), fok);
        chk("loads", loads_exp, loads);
    endtask : check_all

    // send a word and update the shadow copies
    task automatic wr(input logic [31:0] w);
        scw_host_i.send(w);
        case (w[3:0])
            4'h0: begin
                if (w4[14]) div_act = w6[23:21];
                if (!w7[25]) loads_exp++;
            end
            4'h4: w4 = w;
            4'h5: w5 = w;
            4'h6: begin
                w6 = w;
                if (!w4[14]) div_act = w[23:21];
            end
            4'h7: w7 = w;
            4'h8: w8 = w;
            default: ;
        endcase
        check_all();
    endtask : wr

    // random word that still keeps the host's reserved patterns
    function automatic logic [31:0] rnd();
        logic [31:0] w;
        logic [3:0]  a [7];
        a = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hb};
        w = $urandom();
        w[3:0] = a[$urandom_range(0, 6)];
        case (w[3:0])
            4'h4: w[14] = 1'b0;
            4'h5: w = 32'h00800025;
            4'h6: w[31:25] = {1'b0, w[30:29], 4'ha};
            4'h7: w = {6'h04, 16'h0, w[9:4], 4'h7};
            4'h8: w = 32'h102d0428;
            default: ;
        endcase
        return w;
    endfunction : rnd

    task automatic tally_and_finish();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        void'($urandom(31632));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check_all();
        wr(32'h00800025);
        wr(32'h102d0428);
        // load sync holds the divider load until the reference rises
        wr(32'h12000007);
        wr(32'h00000000);
        @(posedge clk) ref_r <= 1'b1;
        repeat (8) @(posedge clk);
        ref_r <= 1'b0;
        loads_exp++;
        wr(32'h10000007);
        // double buffer stages the divider field until word 0
        wr(32'h00004004);
        wr(32'h14a00006);
        wr(32'h00000000);
        wr(32'h00000004);
        for (int p = 0; p < 4; p++) wr(32'h10000007 | (p << 5));
        wr(32'h10000017);
        // gated bleed and mute stay off until lock
        wr(32'h74000a46);
        @(posedge clk) lock_r <= 1'b1;
        repeat (8) @(posedge clk);
        check_all();
        // power-down still loads new words and keeps them
        wr(32'h000000f4);
        wr(32'h1401e2d6);
        wr(32'h00000004);
        wr(32'hfffffffb);
        for (int i = 0; i < 30; i++) begin
            @(posedge clk) lock_r <= $urandom_range(0, 1) != 0;
            wr(rnd());
        end
        tally_and_finish();
    end
endmodule : test_scw_bank
